// ==== hw/muxed_byte_bus_host_port.sv ====
// Multiplexed byte-wide host bus port with both strobe conventions.
// Assumes all bus pins are synchronous to clk and the master keeps its own timing.
`timescale 1ns/1ps
module muxed_byte_bus_host_port
#(
    parameter int DEPTH = host_port_pkg::MEM_DEPTH
)
(
    input  wire logic                               clk,
    input  wire logic                               resetn,
    input  wire logic                               bus_style_strap,
    input  wire logic                               addr_latch_strobe,
    input  wire logic                               read_data_strobe,
    input  wire logic                               rw_strobe,
    input  wire logic                               chip_select_n,
    input  wire logic                               power_fail_threshold,
    input  wire logic [host_port_pkg::DATA_W-1:0]   mux_addr_data_bus_in,
    output logic      [host_port_pkg::DATA_W-1:0]   mux_addr_data_bus_out,
    output logic                                    mux_addr_data_bus_oe_n
);
    import host_port_pkg::*;

    byte_store_if st ();

    logic [7:0] addr_ff;
    logic [7:0] nxt_addr;
    logic       addr_stb_ff;
    logic       nxt_addr_stb;
    logic       data_stb_ff;
    logic       nxt_data_stb;
    logic       rw_ff;
    logic       nxt_rw;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       drive_ff;
    logic       nxt_drive;
    logic       cs_ok;
    logic       level_mode;
    logic       addr_stb_fall;
    logic       addr_stb_rise;
    logic       wr_event;
    logic       rd_window;

    // Power fail masks the chip select before anything uses it.
    assign cs_ok         = !chip_select_n && !power_fail_threshold;
    assign level_mode    = bus_style_strap;
    assign addr_stb_fall = addr_stb_ff && !addr_latch_strobe;
    assign addr_stb_rise = !addr_stb_ff && addr_latch_strobe;

    // Write on data strobe fall with R/W low, or write strobe rising edge.
    always_comb
    begin
        if (level_mode)
        begin
            wr_event  = data_stb_ff && !read_data_strobe && !rw_ff;
            rd_window = read_data_strobe && rw_strobe;
        end
        else
        begin
            wr_event  = !rw_ff && rw_strobe;
            rd_window = !read_data_strobe && rw_strobe;
        end
    end

    // The previous sample of each strobe feeds the edge detectors.
    // Reset values match the idle strobe levels except the data strobe in split mode (idle high, reset low), so no false edge follows reset.
    always_comb
    begin
        nxt_addr_stb = addr_latch_strobe;
        nxt_data_stb = read_data_strobe;
        nxt_rw       = rw_strobe;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_stb_ff <= 1'b0;
            data_stb_ff <= 1'b0;
            rw_ff       <= 1'b1;
        end
        else
        begin
            addr_stb_ff <= nxt_addr_stb;
            data_stb_ff <= nxt_data_stb;
            rw_ff       <= nxt_rw;
        end
    end

    // Address latch and clear.
    always_comb
    begin
        nxt_addr = addr_ff;
        if (addr_stb_fall)
        begin
            nxt_addr = mux_addr_data_bus_in;
        end
        else if (addr_stb_rise)
        begin
            nxt_addr = ADDR_CLEAR;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            addr_ff <= ADDR_CLEAR;
        end
        else
        begin
            addr_ff <= nxt_addr;
        end
    end

    // Read driver: drive while the window is open, float when it closes.
    always_comb
    begin
        nxt_drive = rd_window && cs_ok;
        nxt_rdata = rdata_ff;
        if (rd_window && cs_ok)
        begin
            nxt_rdata = st.rd_data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_ff <= DATA_CLEAR;
            drive_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            drive_ff <= nxt_drive;
        end
    end

    assign st.addr    = addr_ff;
    assign st.wr_data = mux_addr_data_bus_in;
    assign st.wr_en   = wr_event && cs_ok;

    assign mux_addr_data_bus_out  = rdata_ff;
    assign mux_addr_data_bus_oe_n = !drive_ff;

    byte_store #(.DEPTH(DEPTH)) u_store
    (
        .clk (clk),
        .bus (st.store)
    );

    // Strobe events as seen on the pins, independent of the edge registers.
    sequence s_level_write_edge;
        level_mode && $past(read_data_strobe) && !read_data_strobe && !$past(rw_strobe);
    endsequence

    sequence s_split_write_edge;
        !level_mode && !$past(rw_strobe) && rw_strobe;
    endsequence

    sequence s_level_read_open;
        level_mode && read_data_strobe && rw_strobe && cs_ok;
    endsequence

    sequence s_split_read_open;
        !level_mode && !read_data_strobe && rw_strobe && cs_ok;
    endsequence

    sequence s_level_read_close;
        level_mode && $past(read_data_strobe) && !read_data_strobe;
    endsequence

    sequence s_split_read_close;
        !level_mode && !$past(read_data_strobe) && read_data_strobe;
    endsequence

    a_addr_latch: assert property (@(posedge clk) disable iff (!resetn)
        addr_stb_fall |=> addr_ff == $past(mux_addr_data_bus_in))
        else $error("Address not latched on strobe fall.");
    a_addr_clear: assert property (@(posedge clk) disable iff (!resetn)
        addr_stb_rise |=> addr_ff == ADDR_CLEAR)
        else $error("Address not cleared on strobe rise.");
    a_pf_no_write: assert property (@(posedge clk) disable iff (!resetn)
        power_fail_threshold |-> !st.wr_en)
        else $error("Write while power failed.");
    a_pf_no_drive: assert property (@(posedge clk) disable iff (!resetn)
        power_fail_threshold |=> mux_addr_data_bus_oe_n)
        else $error("Bus driven while power failed.");
    a_nocs_no_write: assert property (@(posedge clk) disable iff (!resetn)
        chip_select_n |-> !st.wr_en)
        else $error("Write without chip select.");
    a_nocs_no_drive: assert property (@(posedge clk) disable iff (!resetn)
        chip_select_n |=> mux_addr_data_bus_oe_n)
        else $error("Bus driven without chip select.");
    a_read_drive: assert property (@(posedge clk) disable iff (!resetn)
        (rd_window && cs_ok) |=> !mux_addr_data_bus_oe_n)
        else $error("Read window not driven.");
    a_read_release: assert property (@(posedge clk) disable iff (!resetn)
        !rd_window |=> mux_addr_data_bus_oe_n)
        else $error("Bus not released after read.");
    a_level_write: assert property (@(posedge clk) disable iff (!resetn)
        (s_level_write_edge ##0 cs_ok) |-> st.wr_en)
        else $error("Level style write missed.");
    a_split_write: assert property (@(posedge clk) disable iff (!resetn)
        (s_split_write_edge ##0 cs_ok) |-> st.wr_en)
        else $error("Split style write missed.");
    a_level_read: assert property (@(posedge clk) disable iff (!resetn)
        s_level_read_open |=> !mux_addr_data_bus_oe_n && (mux_addr_data_bus_out == $past(st.rd_data)))
        else $error("Level style read data wrong.");
    a_split_read: assert property (@(posedge clk) disable iff (!resetn)
        s_split_read_open |=> !mux_addr_data_bus_oe_n && (mux_addr_data_bus_out == $past(st.rd_data)))
        else $error("Split style read data wrong.");
    a_level_read_end: assert property (@(posedge clk) disable iff (!resetn)
        s_level_read_close |=> mux_addr_data_bus_oe_n)
        else $error("Level style read not ended.");
    a_split_read_end: assert property (@(posedge clk) disable iff (!resetn)
        s_split_read_close |=> mux_addr_data_bus_oe_n)
        else $error("Split style read not ended.");
    a_write_lands: assert property (@(posedge clk) disable iff (!resetn)
        (st.wr_en && (int'(st.addr) < DEPTH) && !addr_stb_fall && !addr_stb_rise) |=> st.rd_data == $past(st.wr_data))
        else $error("Written byte not stored.");
endmodule

// ==== hw/host_port_pkg.sv ====
// Constants for the multiplexed byte-wide host bus port.
// Assumes a single 40 MHz clock and pins sampled synchronously.
package host_port_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 8;
    localparam int          MEM_DEPTH   = 128;
    localparam logic [7:0]  ADDR_CLEAR  = 8'h00;
    localparam logic [7:0]  DATA_CLEAR  = 8'h00;
endpackage

// ==== hw/byte_store_if.sv ====
// Interface between the host port and its byte store.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface byte_store_if;
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    modport port  (output wr_en, output addr, output wr_data, input rd_data);
    modport store (input wr_en, input addr, input wr_data, output rd_data);
endinterface

// ==== hw/byte_store.sv ====
// Byte array for the clock, control and general-purpose space.
// Assumes writes arrive as one-cycle enables from the host port.
`timescale 1ns/1ps
module byte_store
#(
    parameter int DEPTH = 128
)
(
    input  wire logic   clk,
    byte_store_if.store bus
);
    import host_port_pkg::*;

    localparam int IDX_W = $clog2(DEPTH);

    logic [7:0] mem [DEPTH];

    assign bus.rd_data = (int'(bus.addr) < DEPTH) ? mem[bus.addr[IDX_W-1:0]] : DATA_CLEAR;

    always_ff @(posedge clk)
    begin
        if (bus.wr_en && (int'(bus.addr) < DEPTH))
        begin
            mem[bus.addr[IDX_W-1:0]] <= bus.wr_data;
        end
    end
endmodule

// ==== bench/bus_master_model.sv ====
// Bus master model that drives strobes, chip select and the shared bus.
// Assumes the testbench merges dev_data onto the pins while oe_n is low.
`timescale 1ns/1ps
module bus_master_model
(
    input  wire logic       clk,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_oe_n,
    output logic            strap,
    output logic            addr_stb,
    output logic            data_stb,
    output logic            rw_p,
    output logic            cs_n,
    output logic [7:0]      drv
);
    initial
    begin
        {strap, addr_stb, data_stb, rw_p, cs_n} = 5'b0_0111;
        drv = 8'h00;
    end
    task automatic cyc(input logic lvl, rd, sel, input logic [7:0] a, d, output logic [7:0] q, output logic [1:0] oe);
        @(posedge clk);
        strap <= lvl;
        data_stb <= ~lvl;
        cs_n <= ~sel;
        addr_stb <= 1'b1;
        drv <= a;
        @(posedge clk) addr_stb <= 1'b0;
        @(posedge clk) drv <= rd ? ~a : d;
        @(posedge clk) if (rd) data_stb <= lvl; else rw_p <= 1'b0;
        @(posedge clk) if (!rd) data_stb <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk) q = dev_data;
        oe[0] = dev_oe_n;
        @(posedge clk) data_stb <= ~lvl;
        rw_p <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk) oe[1] = dev_oe_n;
        @(posedge clk) cs_n <= 1'b1;
        drv <= ~drv;
    endtask
endmodule

// ==== bench/test_muxed_byte_bus_host_port.sv ====
// Self-checking testbench for the multiplexed byte bus host port.
// Assumes the port holds its byte store and the master model drives the pins.
`timescale 1ns/1ps
module test_muxed_byte_bus_host_port;
    import host_port_pkg::*;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       pf = 1'b0;
    logic       strap, addr_stb, data_stb, rw_p, cs_n, oe_n;
    logic [7:0] drv, dout, q, d, a;
    logic [1:0] oe;
    logic [7:0] mem [0:MEM_DEPTH-1];
    int         n_errors = 0;
    int         cmp_count = 0;
    always #12.5 clk = ~clk;
    bus_master_model bus_master_model_i (.clk(clk), .dev_data(dout), .dev_oe_n(oe_n), .strap(strap),
        .addr_stb(addr_stb), .data_stb(data_stb), .rw_p(rw_p), .cs_n(cs_n), .drv(drv));
    muxed_byte_bus_host_port muxed_byte_bus_host_port_i (.clk(clk), .resetn(resetn), .bus_style_strap(strap),
        .addr_latch_strobe(addr_stb), .read_data_strobe(data_stb), .rw_strobe(rw_p), .chip_select_n(cs_n),
        .power_fail_threshold(pf), .mux_addr_data_bus_in(oe_n ? drv : dout),
        .mux_addr_data_bus_out(dout), .mux_addr_data_bus_oe_n(oe_n));
    function automatic logic [7:0] expect_rd(input logic [7:0] x);
        return (x < MEM_DEPTH) ? mem[x] : DATA_CLEAR;
    endfunction
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (10000) @(posedge clk);
        n_errors++;
        summarize();
    end
    initial
    begin
        void'($urandom(97));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk) chk("oe_n_reset", 8'h01, {7'h0, oe_n});
        for (int i = 0; i < 40; i++)
        begin
            a = (i < 3) ? 8'h7f + 8'(i) : 8'($urandom);
            d = 8'($urandom);
            bus_master_model_i.cyc(i[0], 1'b0, 1'b1, a, d, q, oe);
            if (a < MEM_DEPTH)
                mem[a] = d;
            bus_master_model_i.cyc(i[1], 1'b1, 1'b1, a, 8'h00, q, oe);
            chk("rd_data", expect_rd(a), q);
            chk("rd_oe_n", 8'h02, {6'h0, oe});
            @(posedge clk) pf <= i[2];
            bus_master_model_i.cyc(i[3], 1'b0, i[2], a, ~d, q, oe);
            bus_master_model_i.cyc(i[3], 1'b1, i[2], a, 8'h00, q, oe);
            chk("blocked_oe_n", 8'h03, {6'h0, oe});
            @(posedge clk) pf <= 1'b0;
            bus_master_model_i.cyc(~i[3], 1'b1, 1'b1, a, 8'h00, q, oe);
            chk("kept_data", expect_rd(a), q);
        end
        summarize();
    end
endmodule
